/* File: rtl/pmb_cmd_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmb_params.svh"
module pmb_cmd_core
  import pmb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Decoded command from the serial front end
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdHasData,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdData,
  // Answer to the front end
  output logic rspValid,
  output logic [7:0] rspData,
  output logic invalidDataEvt,
  output logic invalidCmdEvt,
  output logic nvmBusy,
  // Straps and pin detection
  input wire logic [1:0] phaseCount,
  input wire logic [7:0] strapOverrideSelect,
  input wire logic [63:0] strapValues,
  // Converter controls
  output logic [3:0] regulationEn,
  output logic [31:0] outputSetpoint
);
  // State
  pmb_byte_t unitSel_reg; // Phase routing
  pmb_byte_t guard_reg; // Write guard level
  pmb_byte_t opMem [4][8]; // Operating memory per phase
  logic rspValid_reg; // Answer strobe
  pmb_byte_t rspData_reg; // Answer byte
  logic badData_reg; // Invalid data pulse
  logic badCmd_reg; // Invalid command pulse
  logic [3:0] regEn_reg; // Regulation enables
  logic [31:0] setpoint_reg; // Setpoints, phase 0 low

  // Decode
  logic take; // Command accepted
  logic itemHit; // Code is an item
  pmb_item_t itemIdx; // Item slot of the code
  logic known; // Code is supported
  logic allowed; // Guard passes the write
  logic unitOk; // Unit select value usable
  logic guardOk; // Guard value legal
  logic itemWr; // Item write goes ahead
  logic [1:0] rdPhase; // Phase read back
  pmb_nvm_if nvm ();

  // Item table lookup
  function automatic logic [3:0] itemLookup(input logic [7:0] code);
    case (code)
      `PMB_CMD_RUN_CTRL: itemLookup = {1'b1, `PMB_ITEM_RUN};
      `PMB_CMD_START_STOP: itemLookup = {1'b1, `PMB_ITEM_START_STOP};
      `PMB_CMD_SETPOINT: itemLookup = {1'b1, `PMB_ITEM_SETPOINT};
      `PMB_CMD_ITEM3: itemLookup = 4'hB;
      `PMB_CMD_ITEM4: itemLookup = 4'hC;
      `PMB_CMD_ITEM5: itemLookup = 4'hD;
      `PMB_CMD_ITEM6: itemLookup = 4'hE;
      `PMB_CMD_ITEM7: itemLookup = 4'hF;
      default: itemLookup = 4'h0;
    endcase
  endfunction : itemLookup

  // Which writes each guard level lets through
  function automatic logic guardAllows(input logic [7:0] lvl, input logic [7:0] code);
    logic core3;
    core3 = (code == `PMB_CMD_WRITE_GUARD) || (code == `PMB_CMD_NVM_SAVE);
    case (lvl)
      `PMB_GUARD_OPEN: guardAllows = 1'b1;
      `PMB_GUARD_L20: guardAllows = core3 || (code == `PMB_CMD_RUN_CTRL)
        || (code == `PMB_CMD_START_STOP) || (code == `PMB_CMD_SETPOINT);
      `PMB_GUARD_L40: guardAllows = core3 || (code == `PMB_CMD_RUN_CTRL);
      `PMB_GUARD_L80: guardAllows = core3;
      default: guardAllows = code == `PMB_CMD_WRITE_GUARD;
    endcase
  endfunction : guardAllows

  // Commands arriving during a save or reload are dropped
  assign take = cmdValid && !nvm.busy;
  assign {itemHit, itemIdx} = itemLookup(cmdCode);
  assign known = itemHit || (cmdCode == `PMB_CMD_UNIT_SEL)
    || (cmdCode == `PMB_CMD_WRITE_GUARD) || (cmdCode == `PMB_CMD_NVM_SAVE)
    || (cmdCode == `PMB_CMD_NVM_RELOAD) || (cmdCode == `PMB_CMD_FEATURE);
  assign allowed = guardAllows(guard_reg, cmdCode);
  // Only selected phases that exist, or the all-phase value
  assign unitOk = (cmdData == `PMB_UNIT_ALL)
    || (cmdData <= {6'h00, phaseCount});
  assign guardOk = (cmdData == `PMB_GUARD_OPEN) || (cmdData == `PMB_GUARD_L20)
    || (cmdData == `PMB_GUARD_L40) || (cmdData == `PMB_GUARD_L80);
  assign itemWr = take && cmdWrite && cmdHasData && itemHit && allowed;
  assign rdPhase = (unitSel_reg == `PMB_UNIT_ALL) ? 2'h0 : unitSel_reg[1:0];

  // Engine hookup; save reads phase 0, all phases match under FFh
  assign nvm.startSave = take && cmdWrite && !cmdHasData && allowed
    && (cmdCode == `PMB_CMD_NVM_SAVE);
  assign nvm.startReload = take && cmdWrite && !cmdHasData && allowed
    && (cmdCode == `PMB_CMD_NVM_RELOAD);
  assign nvm.opRData = opMem[0][nvm.itemIdx];
  assign nvm.strapData = strapValues[8 * nvm.itemIdx +: 8];
  assign nvm.strapSel = strapOverrideSelect[nvm.itemIdx];

  pmb_nvm_engine u_engine (
    .clk_sys(clk_sys),
    .rst(rst),
    .nvm(nvm.eng)
  );

  // Unit select register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unitSel_reg <= `PMB_UNIT_RST;
    end else if (take && cmdWrite && cmdHasData && allowed
                 && cmdCode == `PMB_CMD_UNIT_SEL && unitOk) begin
      unitSel_reg <= cmdData;
    end
  end

  // Write guard register; always writable at any level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      guard_reg <= `PMB_GUARD_RST;
    end else if (take && cmdWrite && cmdHasData
                 && cmdCode == `PMB_CMD_WRITE_GUARD && guardOk) begin
      guard_reg <= cmdData;
    end
  end

  // Operating memory, one slice per phase
  generate
    for (genvar p = 0; p < 4; p++) begin : g_phase
      logic hitPhase; // Write aimed at this phase
      assign hitPhase = (unitSel_reg == `PMB_UNIT_ALL)
        || (unitSel_reg[1:0] == 2'(p));
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          for (int i = 0; i < 8; i++) opMem[p][i] <= 8'h00;
        end else if (nvm.opWe) begin
          opMem[p][nvm.itemIdx] <= nvm.opWData;
        end else if (itemWr && hitPhase) begin
          opMem[p][itemIdx] <= cmdData;
        end
      end
    end
  endgenerate

  // Answer and error pulses, one cycle after the command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rspValid_reg <= 1'b0;
      rspData_reg <= 8'h00;
      badData_reg <= 1'b0;
      badCmd_reg <= 1'b0;
    end else begin
      rspValid_reg <= take;
      badData_reg <= 1'b0;
      badCmd_reg <= 1'b0;
      if (take && cmdWrite) begin
        rspData_reg <= 8'h00;
        // Unknown code, wrong form or guarded write
        if (!known || !allowed) begin
          badCmd_reg <= 1'b1;
        end else if ((cmdCode == `PMB_CMD_NVM_SAVE || cmdCode == `PMB_CMD_NVM_RELOAD)
                     == cmdHasData) begin
          badCmd_reg <= 1'b1;
        end else if (cmdCode == `PMB_CMD_UNIT_SEL) begin
          badData_reg <= !unitOk;
        end else if (cmdCode == `PMB_CMD_WRITE_GUARD) begin
          badData_reg <= !guardOk;
        end else if (cmdCode == `PMB_CMD_FEATURE) begin
          badData_reg <= 1'b1;
        end
      end else if (take) begin
        // Reads ignore the guard level entirely
        if (!known || cmdCode == `PMB_CMD_NVM_SAVE || cmdCode == `PMB_CMD_NVM_RELOAD) begin
          badCmd_reg <= 1'b1;
          rspData_reg <= 8'h00;
        end else if (itemHit) begin
          rspData_reg <= opMem[rdPhase][itemIdx];
        end else if (cmdCode == `PMB_CMD_UNIT_SEL) begin
          rspData_reg <= unitSel_reg;
        end else if (cmdCode == `PMB_CMD_WRITE_GUARD) begin
          rspData_reg <= guard_reg;
        end else begin
          rspData_reg <= `PMB_FEATURE_VAL;
        end
      end
    end
  end

  // Converter controls; reload holds regulation off throughout
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regEn_reg <= 4'h0;
      setpoint_reg <= 32'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        regEn_reg[p] <= opMem[p][`PMB_ITEM_RUN][`PMB_RUN_BIT] && !nvm.regStop;
        setpoint_reg[8 * p +: 8] <= opMem[p][`PMB_ITEM_SETPOINT];
      end
    end
  end

  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;
  assign invalidDataEvt = badData_reg;
  assign invalidCmdEvt = badCmd_reg;
  assign nvmBusy = nvm.busy;
  assign regulationEn = regEn_reg;
  assign outputSetpoint = setpoint_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  unit_reset_a: assert property ($past(rst) |-> unitSel_reg == `PMB_UNIT_RST)
    else $error("unit select not FFh after reset");
  unit_reject_a: assert property (take && cmdWrite && cmdHasData && allowed
      && cmdCode == `PMB_CMD_UNIT_SEL && cmdData > 8'h03 && cmdData < 8'hFF
      |=> invalidDataEvt && $stable(unitSel_reg))
    else $error("bad unit select accepted");
  all_phase_a: assert property (itemWr && unitSel_reg == `PMB_UNIT_ALL && !nvm.opWe
      |=> opMem[3][$past(itemIdx)] == $past(cmdData) && opMem[0][$past(itemIdx)] == $past(cmdData))
    else $error("all-phase write missed a phase");
  guard_open_a: assert property (take && cmdWrite && cmdHasData && itemHit
      && guard_reg == `PMB_GUARD_OPEN |=> !invalidCmdEvt)
    else $error("open guard refused write");
  guard_l40_a: assert property (take && cmdWrite && guard_reg == `PMB_GUARD_L40
      && cmdCode == `PMB_CMD_SETPOINT |=> invalidCmdEvt && $stable(outputSetpoint))
    else $error("level 40h let setpoint through");
  guard_bad_a: assert property (take && cmdWrite && cmdHasData
      && cmdCode == `PMB_CMD_WRITE_GUARD && !guardOk |=> invalidDataEvt && $stable(guard_reg))
    else $error("bad guard value accepted");
  read_free_a: assert property (take && !cmdWrite && itemHit
      |=> rspValid && !invalidCmdEvt)
    else $error("read refused");
  feature_val_a: assert property (take && !cmdWrite && cmdCode == `PMB_CMD_FEATURE
      |=> rspData == 8'hD0)
    else $error("feature byte wrong");
  reload_stop_a: assert property (nvm.startReload |=> ##1 regulationEn == 4'h0 [*2])
    else $error("regulation not stopped on reload");
  save_busy_a: assert property (nvm.startSave |=> nvmBusy ##1 !rspValid)
    else $error("save did not block commands");
  // A busy engine gives no answer to whatever arrives
  nvm_drop_a: assert property (nvmBusy && cmdValid |=> !rspValid)
    else $error("command answered while busy");
  // Accepted unit select lands unchanged
  unit_phase_a: assert property (take && cmdWrite && cmdHasData && allowed
      && cmdCode == `PMB_CMD_UNIT_SEL && unitOk |=> unitSel_reg == $past(cmdData))
    else $error("unit select not stored");
  // Existing phases only; the strap sets how many
  unit_range_a: assert property (take && cmdWrite && cmdHasData && allowed
      && cmdCode == `PMB_CMD_UNIT_SEL && cmdData != 8'hFF
      && cmdData > {6'h00, phaseCount} |=> invalidDataEvt)
    else $error("missing phase accepted");
  // Unit select reads back its present value
  unit_rsp_a: assert property (take && !cmdWrite && cmdCode == `PMB_CMD_UNIT_SEL
      |=> rspData == $past(unitSel_reg))
    else $error("unit select read wrong");
  // Level 20h keeps generic items locked
  guard_l20_a: assert property (take && cmdWrite && cmdHasData
      && guard_reg == `PMB_GUARD_L20 && cmdCode == `PMB_CMD_ITEM3 |=> invalidCmdEvt)
    else $error("level 20h let item through");
  // Level 80h locks run control too
  guard_l80_a: assert property (take && cmdWrite && guard_reg == `PMB_GUARD_L80
      && cmdCode == `PMB_CMD_RUN_CTRL |=> invalidCmdEvt)
    else $error("level 80h let run control through");
  // Legal guard values are stored without complaint
  guard_take_a: assert property (take && cmdWrite && cmdHasData
      && cmdCode == `PMB_CMD_WRITE_GUARD && guardOk |=> guard_reg == $past(cmdData) && !invalidDataEvt)
    else $error("legal guard value refused");
  // Reload is refused at every guard level except 00h
  guard_reload_a: assert property (take && cmdWrite && cmdCode == `PMB_CMD_NVM_RELOAD
      && guard_reg != `PMB_GUARD_OPEN |-> !nvm.startReload)
    else $error("guarded reload started");
  // Blocked item writes leave memory alone
  blocked_keep_a: assert property (take && cmdWrite && cmdHasData && itemHit && !allowed
      |=> invalidCmdEvt && opMem[0][$past(itemIdx)] == $past(opMem[0][itemIdx]))
    else $error("blocked write changed memory");
  // The feature byte refuses every write
  feature_ro_a: assert property (take && cmdWrite && cmdHasData && allowed
      && cmdCode == `PMB_CMD_FEATURE |=> invalidDataEvt)
    else $error("feature byte write accepted");
  // Item reads under FFh return the phase 0 copy
  read_rsp_a: assert property (take && !cmdWrite && itemHit && unitSel_reg == `PMB_UNIT_ALL
      |=> rspData == $past(opMem[0][itemIdx]))
    else $error("item read wrong");
  // Writes answer with a zero byte
  write_zero_a: assert property (take && cmdWrite |=> rspData == 8'h00)
    else $error("write answer not zero");
  // Data flag always rides with an answer
  flag_pair_a: assert property (invalidDataEvt |-> rspValid)
    else $error("data flag without answer");
  // Command flag rides alone with its answer
  cmd_pair_a: assert property (invalidCmdEvt |-> rspValid && !invalidDataEvt)
    else $error("command flag malformed");
  // Save starts a walk without stopping regulation
  save_walk_a: assert property (nvm.startSave |=> nvmBusy && !nvm.regStop)
    else $error("save walk did not start");
  // Reload enters its stop phase first
  reload_busy_a: assert property (nvm.startReload |=> nvm.regStop)
    else $error("reload did not stop first");
  // Reload only overwrites memory while regulation is held off
  load_stop_a: assert property (nvm.opWe |-> nvm.regStop)
    else $error("reload wrote while regulating");
  // Phase 0 setpoint follows its item one clock later
  setpoint_follow_a: assert property (!$past(rst)
      |-> outputSetpoint[7:0] == $past(opMem[0][`PMB_ITEM_SETPOINT]))
    else $error("setpoint output lags item");

  save_c: cover property (nvm.startSave ##[1:100] !nvmBusy);
  reload_c: cover property (nvm.startReload ##[1:40] !nvmBusy);
  blocked_c: cover property (take && cmdWrite && !allowed);
  // Single-phase writes and refused unit values
  phase_wr_c: cover property (itemWr && unitSel_reg != `PMB_UNIT_ALL);
  bad_unit_c: cover property (take && cmdWrite && cmdCode == `PMB_CMD_UNIT_SEL && !unitOk);
endmodule : pmb_cmd_core
`default_nettype wire

/* File: rtl/pmb_params.svh */
`ifndef PMB_PARAMS_SVH
`define PMB_PARAMS_SVH
// Command codes handled outside the item table
`define PMB_CMD_UNIT_SEL 8'h04
`define PMB_CMD_WRITE_GUARD 8'h10
`define PMB_CMD_NVM_SAVE 8'h15
`define PMB_CMD_NVM_RELOAD 8'h16
`define PMB_CMD_FEATURE 8'h19
// Operating-memory items, one byte each
`define PMB_CMD_RUN_CTRL 8'h01
`define PMB_CMD_START_STOP 8'h02
`define PMB_CMD_SETPOINT 8'h21
`define PMB_CMD_ITEM3 8'h22
`define PMB_CMD_ITEM4 8'h24
`define PMB_CMD_ITEM5 8'h33
`define PMB_CMD_ITEM6 8'h35
`define PMB_CMD_ITEM7 8'h60
`define PMB_ITEM_RUN 3'h0
`define PMB_ITEM_START_STOP 3'h1
`define PMB_ITEM_SETPOINT 3'h2
`define PMB_ITEM_LAST 3'h7
`define PMB_RUN_BIT 7
// Items that own a user-store location
`define PMB_ITEM_STORE_MASK 8'h7F
// Unit select values
`define PMB_UNIT_ALL 8'hFF
`define PMB_UNIT_RST 8'hFF
// Write guard levels
`define PMB_GUARD_OPEN 8'h00
`define PMB_GUARD_L20 8'h20
`define PMB_GUARD_L40 8'h40
`define PMB_GUARD_L80 8'h80
`define PMB_GUARD_RST 8'h00
// Feature summary: PEC, 1 MHz, alert
`define PMB_FEATURE_VAL 8'hD0
// Timing of one nonvolatile byte program
`define PMB_CLK_PERIOD_NS 20
`define PMB_NVM_WRITE_NS 100
`define PMB_NVM_WRITE_CYC ((`PMB_NVM_WRITE_NS + `PMB_CLK_PERIOD_NS - 1) / `PMB_CLK_PERIOD_NS)
`endif

/* File: rtl/pmb_pkg.sv */
package pmb_pkg;
  // Byte and item index types
  typedef logic [7:0] pmb_byte_t;
  typedef logic [2:0] pmb_item_t;
  // Nonvolatile copy engine states
  typedef enum logic [2:0] {
    ENG_IDLE,
    ENG_SAVE,
    ENG_WAIT,
    ENG_STOP,
    ENG_LOAD,
    ENG_STRAP
  } pmb_eng_state_e;
endpackage : pmb_pkg

/* File: rtl/pmb_nvm_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pmb_nvm_if;
  import pmb_pkg::*;
  logic startSave;
  logic startReload;
  logic busy;
  logic regStop;
  pmb_item_t itemIdx;
  pmb_byte_t opRData;
  logic opWe;
  pmb_byte_t opWData;
  pmb_byte_t strapData;
  logic strapSel;
  // Copy engine side
  modport eng (
    input startSave, startReload, opRData, strapData, strapSel,
    output busy, regStop, itemIdx, opWe, opWData
  );
  // Command core side
  modport core (
    output startSave, startReload, opRData, strapData, strapSel,
    input busy, regStop, itemIdx, opWe, opWData
  );
endinterface : pmb_nvm_if
`default_nettype wire

/* File: rtl/pmb_nvm_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmb_params.svh"
module pmb_nvm_engine
  import pmb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Core link
  pmb_nvm_if.eng nvm
);
  localparam logic [7:0] STORE_MASK = `PMB_ITEM_STORE_MASK;
  localparam logic [3:0] WRITE_CYC = 4'(`PMB_NVM_WRITE_CYC);

  pmb_eng_state_e state_reg; // Sequencer state
  pmb_item_t idx_reg; // Item walked
  logic [3:0] wait_reg; // Program time left
  pmb_byte_t userStore [8]; // User store contents
  logic hasStore; // Item owns a store slot

  assign hasStore = STORE_MASK[idx_reg];
  assign nvm.busy = (state_reg != ENG_IDLE);
  assign nvm.regStop = (state_reg == ENG_STOP) || (state_reg == ENG_LOAD)
    || (state_reg == ENG_STRAP);
  assign nvm.itemIdx = idx_reg;

  // Operating-memory writes during reload
  always_comb begin
    nvm.opWe = 1'b0;
    nvm.opWData = userStore[idx_reg];
    case (state_reg)
      ENG_LOAD: nvm.opWe = hasStore;
      ENG_STRAP: begin
        nvm.opWe = nvm.strapSel;
        nvm.opWData = nvm.strapData;
      end
      default: nvm.opWe = 1'b0;
    endcase
  end

  // Sequencer: save walks items, reload stops, loads, then overlays straps
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ENG_IDLE;
      idx_reg <= 3'h0;
      wait_reg <= 4'h0;
    end else begin
      case (state_reg)
        ENG_IDLE: begin
          idx_reg <= 3'h0;
          if (nvm.startSave) state_reg <= ENG_SAVE;
          else if (nvm.startReload) state_reg <= ENG_STOP;
        end
        ENG_SAVE: begin
          if (hasStore) begin
            wait_reg <= WRITE_CYC - 4'h1;
            state_reg <= ENG_WAIT;
          end else if (idx_reg == `PMB_ITEM_LAST) begin
            state_reg <= ENG_IDLE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        ENG_WAIT: begin
          if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
          else if (idx_reg == `PMB_ITEM_LAST) state_reg <= ENG_IDLE;
          else begin
            idx_reg <= idx_reg + 3'h1;
            state_reg <= ENG_SAVE;
          end
        end
        ENG_STOP: state_reg <= ENG_LOAD;
        ENG_LOAD: begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == `PMB_ITEM_LAST) state_reg <= ENG_STRAP;
        end
        ENG_STRAP: begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == `PMB_ITEM_LAST) state_reg <= ENG_IDLE;
        end
        default: state_reg <= ENG_IDLE;
      endcase
    end
  end

  // User store writes; cleared at reset to keep reloads defined
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) userStore[i] <= 8'h00;
    end else if (state_reg == ENG_SAVE && hasStore) begin
      userStore[idx_reg] <= nvm.opRData;
    end
  end
endmodule : pmb_nvm_engine
`default_nettype wire

/* File: tb/pmb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmb_host_model (
  // Clock
  input wire logic clk_sys,
  // Command port toward the device
  output logic cmdValid,
  output logic cmdWrite,
  output logic cmdHasData,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdData,
  // Answer from the device
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic invalidDataEvt,
  input wire logic invalidCmdEvt
);
  logic [7:0] lastUnit; // Unit value last accepted by the device

  // Quiet bus at time zero
  initial begin
    lastUnit = 8'hFF;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdHasData = 1'b0;
    cmdCode = 8'h00;
    cmdData = 8'h00;
  end

  // One command pulse; answer sampled once the taking edge has landed
  task automatic pulse(input logic w, input logic d, input logic [7:0] c, input logic [7:0] v,
                       output logic [10:0] rsp);
    @(posedge clk_sys);
    #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdHasData = d;
    cmdCode = c;
    cmdData = v;
    @(posedge clk_sys);
    #1;
    rsp = {rspValid, invalidDataEvt, invalidCmdEvt, rspData};
    cmdValid = 1'b0;
    // Released lines must not look like the last command
    cmdCode = ~cmdCode;
    cmdData = ~cmdData;
    if (w && d && c == 8'h04 && rsp[10:8] === 3'b100) begin
      lastUnit = v;
    end
  endtask : pulse

  // Host command; a save first selects all phases so no mixed copy is stored
  task automatic issue(input logic w, input logic d, input logic [7:0] c, input logic [7:0] v,
                       output logic [10:0] rsp);
    logic [10:0] tmp;
    if (c == 8'h15 && lastUnit !== 8'hFF) begin
      pulse(1'b1, 1'b1, 8'h04, 8'hFF, tmp);
    end
    pulse(w, d, c, v, rsp);
  endtask : issue
endmodule : pmb_host_model
`default_nettype wire

/* File: tb/pmbus_phase_protect_nvm_cmds_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmb_params.svh"
module pmbus_phase_protect_nvm_cmds_test;
  import pmb_pkg::*;
  // Clock, reset and straps
  logic clk_sys;
  logic rst;
  logic [1:0] phaseCount;
  logic [7:0] strapOverrideSelect;
  logic [63:0] strapValues;
  // Command port
  logic cmdValid, cmdWrite, cmdHasData;
  logic [7:0] cmdCode, cmdData;
  // Answers and converter controls
  logic rspValid, invalidDataEvt, invalidCmdEvt, nvmBusy;
  logic [7:0] rspData;
  logic [3:0] regulationEn;
  logic [31:0] outputSetpoint;
  int miscompares = 0; // Mismatch count
  int checks_done = 0; // Comparison count
  logic [10:0] r; // {valid, bad data, bad command, byte}

  pmb_cmd_core pmb_cmd_core_i (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdHasData(cmdHasData), .cmdCode(cmdCode), .cmdData(cmdData),
    .rspValid(rspValid), .rspData(rspData), .invalidDataEvt(invalidDataEvt),
    .invalidCmdEvt(invalidCmdEvt), .nvmBusy(nvmBusy), .phaseCount(phaseCount),
    .strapOverrideSelect(strapOverrideSelect), .strapValues(strapValues),
    .regulationEn(regulationEn), .outputSetpoint(outputSetpoint));

  pmb_host_model pmb_host_model_i (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdHasData(cmdHasData), .cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid),
    .rspData(rspData), .invalidDataEvt(invalidDataEvt), .invalidCmdEvt(invalidCmdEvt));

  // Free-running 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Comparison and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Bus shorthands
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    pmb_host_model_i.issue(1'b1, 1'b1, c, v, r);
  endtask : wr
  task automatic rd(input logic [7:0] c);
    pmb_host_model_i.issue(1'b0, 1'b0, c, 8'h00, r);
  endtask : rd
  task automatic send(input logic [7:0] c);
    pmb_host_model_i.issue(1'b1, 1'b0, c, 8'h00, r);
  endtask : send
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask : settle

  // Host holds off until the copy ends; bounded so a hang is reported
  task automatic waitIdle;
    int n;
    n = 0;
    while (nvmBusy !== 1'b0 && n < 300) begin
      settle();
      n++;
    end
    if (nvmBusy !== 1'b0) begin
      miscompares++;
      results();
    end
  endtask : waitIdle

  function automatic logic [7:0] itemCode(input int k);
    case (k)
      0: return `PMB_CMD_RUN_CTRL;
      1: return `PMB_CMD_START_STOP;
      2: return `PMB_CMD_SETPOINT;
      default: return `PMB_CMD_ITEM3;
    endcase
  endfunction : itemCode

  // Reset values and the read-only feature byte
  task automatic scnReset;
    rd(`PMB_CMD_UNIT_SEL);
    check(r, {3'b100, 8'hFF});
    rd(`PMB_CMD_FEATURE);
    check(r, {3'b100, 1'b1, 2'b10, 1'b1, 4'h0});
    wr(`PMB_CMD_FEATURE, 8'h00);
    check(r, 11'h600);
    rd(`PMB_CMD_NVM_SAVE);
    check(r, 11'h500);
    wr(`PMB_CMD_NVM_SAVE, 8'h00);
    check(r, 11'h500);
    send(`PMB_CMD_ITEM5);
    check(r, 11'h500);
    wr(`PMB_CMD_ITEM6, 8'h5C);
    rd(`PMB_CMD_ITEM6);
    check(r, {3'b100, 8'h5C});
  endtask : scnReset

  // Phase selection, range edges and strap-limited phase count
  task automatic scnUnit;
    for (int u = 0; u < 4; u++) begin
      wr(`PMB_CMD_UNIT_SEL, u[7:0]);
      check(r, 11'h400);
      rd(`PMB_CMD_UNIT_SEL);
      check(r, {3'b100, u[7:0]});
    end
    for (int i = 0; i < 3; i++) begin
      wr(`PMB_CMD_UNIT_SEL, (i == 0) ? 8'h04 : (i == 1) ? 8'h7F : 8'hFE);
      check(r, 11'h600);
    end
    rd(`PMB_CMD_UNIT_SEL);
    check(r, {3'b100, 8'h03});
    phaseCount = 2'd1;
    wr(`PMB_CMD_UNIT_SEL, 8'h02);
    check(r, 11'h600);
    wr(`PMB_CMD_UNIT_SEL, 8'h01);
    check(r, 11'h400);
    phaseCount = 2'd3;
    wr(`PMB_CMD_UNIT_SEL, 8'hFF);
    check(r, 11'h400);
  endtask : scnUnit

  // Every guard level against writable and blocked items
  task automatic scnGuard;
    logic [7:0] prev [4];
    logic [7:0] lvl, v;
    int cnt;
    prev = '{8'h00, 8'h00, 8'h00, 8'h00};
    for (int l = 0; l < 4; l++) begin
      lvl = (l == 0) ? 8'h00 : (8'h20 << (l - 1));
      cnt = (l == 0) ? 4 : (l == 1) ? 3 : (l == 2) ? 1 : 0;
      wr(`PMB_CMD_WRITE_GUARD, lvl);
      check(r, 11'h400);
      rd(`PMB_CMD_WRITE_GUARD);
      check(r, {3'b100, lvl});
      for (int k = 0; k < 4; k++) begin
        v = 8'h10 + 8'(l * 4 + k);
        wr(itemCode(k), v);
        check(r, (k < cnt) ? 11'h400 : 11'h500);
        if (k < cnt) prev[k] = v;
        rd(itemCode(k));
        check(r, {3'b100, prev[k]});
      end
    end
    for (int i = 0; i < 3; i++) begin
      wr(`PMB_CMD_WRITE_GUARD, (i == 0) ? 8'h01 : (i == 1) ? 8'h30 : 8'hFF);
      check(r, 11'h600);
    end
    rd(`PMB_CMD_WRITE_GUARD);
    check(r, {3'b100, 8'h80});
    wr(`PMB_CMD_UNIT_SEL, 8'h00);
    check(r, 11'h500);
    send(`PMB_CMD_NVM_RELOAD);
    check(r, 11'h500);
    wr(`PMB_CMD_WRITE_GUARD, 8'h00);
    check(r, 11'h400);
  endtask : scnGuard

  // Single phase versus all phases on the setpoint
  task automatic scnPhase;
    wr(`PMB_CMD_SETPOINT, 8'h33);
    settle();
    check(outputSetpoint, 32'h33333333);
    wr(`PMB_CMD_UNIT_SEL, 8'h02);
    wr(`PMB_CMD_SETPOINT, 8'h5A);
    settle();
    check(outputSetpoint, 32'h335A3333);
    rd(`PMB_CMD_SETPOINT);
    check(r, {3'b100, 8'h5A});
    wr(`PMB_CMD_UNIT_SEL, 8'hFF);
  endtask : scnPhase

  // Save under the strictest guard, then reload with a strap overlay
  task automatic scnNvm;
    wr(`PMB_CMD_ITEM3, 8'hA1);
    wr(`PMB_CMD_SETPOINT, 8'h44);
    wr(`PMB_CMD_RUN_CTRL, 8'h80);
    wr(`PMB_CMD_ITEM7, 8'h66);
    wr(`PMB_CMD_ITEM4, 8'h11);
    settle();
    check(regulationEn, 4'hF);
    wr(`PMB_CMD_WRITE_GUARD, 8'h80);
    send(`PMB_CMD_NVM_SAVE);
    check(r, 11'h400);
    check(nvmBusy, 1'b1);
    rd(`PMB_CMD_FEATURE);
    check(r[10:8], 3'b000);
    waitIdle();
    wr(`PMB_CMD_WRITE_GUARD, 8'h00);
    wr(`PMB_CMD_ITEM3, 8'h00);
    wr(`PMB_CMD_ITEM7, 8'h77);
    wr(`PMB_CMD_SETPOINT, 8'h00);
    wr(`PMB_CMD_ITEM4, 8'h22);
    strapOverrideSelect = 8'h10;
    strapValues = 64'h000000C3_00000000;
    send(`PMB_CMD_NVM_RELOAD);
    check(r, 11'h400);
    check(nvmBusy, 1'b1);
    settle();
    check(regulationEn, 4'h0);
    waitIdle();
    rd(`PMB_CMD_ITEM3);
    check(r, {3'b100, 8'hA1});
    rd(`PMB_CMD_ITEM7);
    check(r, {3'b100, 8'h77});
    rd(`PMB_CMD_ITEM4);
    check(r, {3'b100, 8'hC3});
    check(outputSetpoint, 32'h44444444);
    check(regulationEn, 4'hF);
  endtask : scnNvm

  // Main sequence
  initial begin
    rst = 1'b1;
    phaseCount = 2'd3;
    strapOverrideSelect = 8'h00;
    strapValues = 64'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    scnReset();
    scnUnit();
    scnGuard();
    scnPhase();
    scnNvm();
    results();
  end
endmodule : pmbus_phase_protect_nvm_cmds_test
`default_nettype wire
